// >>> rtl/lvdc_top.sv
// Low-voltage detect control with AXI4-Lite registers, interrupt and reset request
`timescale 1ns/100ps
`include "lvdc_consts.svh"

// How it works
// [RULE1] Clearing detector_on while low raises flag; the code does this only in interrupt mode, reset mode sets no flag
// [RULE2] Level select upper four bits written zero
// [RULE3] Level select unchanged while detector runs; the code does not lock it, a write while running takes effect at once
// [RULE4] External source ignores level select entirely
// [RULE5] Reset mode chosen above level: no reset
// [RULE6] Reset mode, external input above: no reset
// [RULE7] Unmasked interrupt may fire right after enable
// [RULE8] Reset follows comparator unfiltered, may chatter
// [RULE9] Interrupt may repeat often, software suppresses
// [RULE10] Stop by zero byte or clearing detector_on
// [RULE11] Mode select picks reset or interrupt
// [RULE12] Comparator results synchronised before use
module lvdc_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Analog comparator
    input  wire lvdc_pkg::lvdc_cmp_t cmp_raw,
    output lvdc_pkg::lvdc_ana_t      cmp_ctrl,
    // Responses
    output logic                     internal_reset_req,
    output logic                     lowvolt_irq
);
    import lvdc_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        addr_is = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction : addr_is

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        addr_known = addr_is(a, `LVDC_OFS_MODE)  || addr_is(a, `LVDC_OFS_LEVEL) ||
                     addr_is(a, `LVDC_OFS_FLAG)  || addr_is(a, `LVDC_OFS_MASK)  ||
                     addr_is(a, `LVDC_OFS_MONITOR);
    endfunction : addr_known

    // ****************************************************************
    // Registers
    // ****************************************************************
    lvdc_mode_t        mode_q;
    logic [3:0]        level_q;
    logic              flag_q;
    logic              mask_q;
    lvdc_state_t       state_q;
    lvdc_state_t       state_d;
    logic              reset_req_q;
    logic              irq_q;

    logic [ADDR_W-1:0] awaddr_q;
    logic              aw_held_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              w_held_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    // ****************************************************************
    // Comparator synchronisation
    // ****************************************************************
    lvdc_cmp_t cmp_sync;

    lvdc_sync #(
        .WIDTH    ($bits(lvdc_cmp_t))
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (cmp_raw),
        .sync_out (cmp_sync)
    ); // RULE12

    // Source select: external input uses its own fixed threshold
    wire below = mode_q.ext_source ? cmp_sync.ext_below : cmp_sync.supply_below; // RULE4

    // ****************************************************************
    // Write channel
    // ****************************************************************
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire wr_fire  = aw_held_q && w_held_q && !bvalid_q;
    wire wr_lane0 = wstrb_q[0];
    wire wr_known = addr_known(awaddr_q);

    wire wr_mode  = wr_fire && wr_lane0 && addr_is(awaddr_q, `LVDC_OFS_MODE);
    wire wr_level = wr_fire && wr_lane0 && addr_is(awaddr_q, `LVDC_OFS_LEVEL);
    wire wr_flag  = wr_fire && wr_lane0 && addr_is(awaddr_q, `LVDC_OFS_FLAG);
    wire wr_mask  = wr_fire && wr_lane0 && addr_is(awaddr_q, `LVDC_OFS_MASK);

    // Accepting address and data separately lets the master present them in any order
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q  <= `LVDC_RDATA_ZERO;
            wstrb_q  <= 4'h0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `LVDC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_known ? `LVDC_RESP_OKAY : `LVDC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // A zero byte or a cleared detector_on both stop the detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= lvdc_mode_t'(`LVDC_RST_MODE);
        end else if (wr_mode) begin
            mode_q <= lvdc_mode_t'(wdata_q[`LVDC_BIT_EXTSRC:0]); // RULE10
        end
    end

    // Only the low nibble is kept; upper bits are expected zero and read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= `LVDC_RST_LEVEL;
        end else if (wr_level) begin
            level_q <= wdata_q[`LVDC_LEVEL_MSB:0]; // RULE2
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= `LVDC_RST_MASK;
        end else if (wr_mask) begin
            mask_q <= wdata_q[`LVDC_BIT_MASK];
        end
    end

    // Level is frozen in hardware only by software discipline; a change mid-run
    // reaches the comparator at once
    assign cmp_ctrl.enable  = mode_q.detector_on;
    assign cmp_ctrl.use_ext = mode_q.ext_source;
    assign cmp_ctrl.level   = mode_q.ext_source ? 4'h0 : level_q; // RULE4 RULE3

    // ****************************************************************
    // Detector state
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            LVDC_OFF: begin
                if (mode_q.detector_on) begin
                    state_d = below ? LVDC_BELOW : LVDC_ABOVE;
                end
            end
            LVDC_ABOVE: begin
                if (!mode_q.detector_on) begin
                    state_d = LVDC_OFF;
                end else if (below) begin
                    state_d = LVDC_BELOW;
                end
            end
            LVDC_BELOW: begin
                if (!mode_q.detector_on) begin
                    state_d = LVDC_OFF;
                end else if (!below) begin
                    state_d = LVDC_ABOVE;
                end
            end
            default: begin
                state_d = LVDC_OFF;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= LVDC_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    wire irq_mode   = !mode_q.reset_mode_select; // RULE11
    wire enter_low  = (state_q != LVDC_BELOW) && mode_q.detector_on && below;
    // Switching off while low is itself a detection event
    wire off_low    = (state_q == LVDC_BELOW) && !mode_q.detector_on; // RULE1
    // In interrupt mode each fresh drop sets the flag again; no hysteresis here
    wire flag_set   = irq_mode && (enter_low || off_low); // RULE9 RULE7
    wire flag_clear = wr_flag && wdata_q[`LVDC_BIT_FLAG];

    // Set wins over a simultaneous write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= `LVDC_RST_FLAG;
        end else if (flag_set) begin
            flag_q <= 1'b1; // RULE1
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end

    // Reset follows the synchronised level directly, so it chatters with the input;
    // selecting reset mode while above gives no pulse
    wire reset_req_d = mode_q.detector_on && mode_q.reset_mode_select &&
                       (state_q == LVDC_BELOW) && below; // RULE5 RULE6 RULE8 RULE11

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_req_q <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            reset_req_q <= reset_req_d;
            irq_q       <= flag_q && !mask_q; // RULE7
        end
    end

    assign internal_reset_req = reset_req_q;
    assign lowvolt_irq        = irq_q;

    // ****************************************************************
    // Read channel
    // ****************************************************************
    wire ar_take = s_axi_arvalid && s_axi_arready;

    wire [31:0] rd_mode  = {29'h0000_0000, mode_q};
    wire [31:0] rd_level = {28'h000_0000, level_q};
    wire [31:0] rd_flag  = {31'h0000_0000, flag_q};
    wire [31:0] rd_mask  = {31'h0000_0000, mask_q};
    wire [31:0] rd_mon   = {29'h0000_0000, mode_q.detector_on, reset_req_q,
                            (state_q == LVDC_BELOW)};

    wire [31:0] rd_mux =
        addr_is(s_axi_araddr, `LVDC_OFS_MODE)    ? rd_mode  :
        addr_is(s_axi_araddr, `LVDC_OFS_LEVEL)   ? rd_level :
        addr_is(s_axi_araddr, `LVDC_OFS_FLAG)    ? rd_flag  :
        addr_is(s_axi_araddr, `LVDC_OFS_MASK)    ? rd_mask  :
        addr_is(s_axi_araddr, `LVDC_OFS_MONITOR) ? rd_mon   : `LVDC_RDATA_ZERO;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= `LVDC_RDATA_ZERO;
            rresp_q  <= `LVDC_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= addr_known(s_axi_araddr) ? `LVDC_RESP_OKAY : `LVDC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : lvdc_top

// >>> rtl/lvdc_consts.svh
// Register offsets, field positions and reset values of the low-voltage detect control
`ifndef LVDC_CONSTS_SVH
`define LVDC_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LVDC_OFS_MODE       8'h00
`define LVDC_OFS_LEVEL      8'h04
`define LVDC_OFS_FLAG       8'h08
`define LVDC_OFS_MASK       8'h0C
`define LVDC_OFS_MONITOR    8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define LVDC_BIT_ON         0
`define LVDC_BIT_RSTMODE    1
`define LVDC_BIT_EXTSRC     2
`define LVDC_LEVEL_MSB      3
`define LVDC_BIT_FLAG       0
`define LVDC_BIT_MASK       0
`define LVDC_BIT_MON_BELOW  0
`define LVDC_BIT_MON_RESET  1
`define LVDC_BIT_MON_ON     2

// ****************************************************************
// Reset values
// ****************************************************************
`define LVDC_RST_MODE       3'h0
`define LVDC_RST_LEVEL      4'h0
`define LVDC_RST_MASK       1'b1
`define LVDC_RST_FLAG       1'b0

// ****************************************************************
// Bus answers
// ****************************************************************
`define LVDC_RESP_OKAY      2'h0
`define LVDC_RESP_SLVERR    2'h2
`define LVDC_RDATA_ZERO     32'h0000_0000

`endif

// >>> rtl/lvdc_pkg.sv
// Types shared by the low-voltage detect control files
package lvdc_pkg;

    // Detector mode register fields, detector_on in bit 0
    typedef struct packed {
        logic ext_source;
        logic reset_mode_select;
        logic detector_on;
    } lvdc_mode_t;

    // Raw comparator results from the analog front end, high while below threshold
    typedef struct packed {
        logic ext_below;
        logic supply_below;
    } lvdc_cmp_t;

    // Outputs that steer the analog comparator
    typedef struct packed {
        logic       enable;
        logic       use_ext;
        logic [3:0] level;
    } lvdc_ana_t;

    // Detector state
    typedef enum logic [1:0] {
        LVDC_OFF,
        LVDC_ABOVE,
        LVDC_BELOW
    } lvdc_state_t;

endpackage : lvdc_pkg

// >>> rtl/lvdc_sync.sv
// Two-flop synchroniser for asynchronous comparator levels
`timescale 1ns/100ps
module lvdc_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : lvdc_sync

// >>> verif/lvdc_assertions.sv
// Port-level concurrent checks for the low-voltage detect control
`timescale 1ns/100ps
module lvdc_assertions (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire lvdc_pkg::lvdc_cmp_t cmp_raw,
    input wire lvdc_pkg::lvdc_ana_t cmp_ctrl,
    input wire logic                internal_reset_req
);
    import lvdc_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************************************
    // Sequences
    // ****************************************************************
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Both comparators above threshold
    sequence s_quiet;
        !cmp_raw.supply_below && !cmp_raw.ext_below;
    endsequence
    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_B_LATENCY: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response missing");
    AST_B_STOP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stayed after handshake");
    AST_R_STOP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stayed after handshake");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready during response");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during read response");
    AST_EXT_LEVEL: assert property (cmp_ctrl.use_ext |-> cmp_ctrl.level == 4'h0)
        else $error("level driven with external source");
    // Reset request is dropped one edge after the detector is switched off
    AST_RST_OFF: assert property (!cmp_ctrl.enable |=> !internal_reset_req)
        else $error("reset request while detector off");
    // Two quiet samples clear the request whatever the synchroniser phase
    AST_RST_QUIET: assert property (s_quiet ##1 s_quiet |-> ##3 !internal_reset_req)
        else $error("reset request without low level");
endmodule : lvdc_assertions

bind lvdc_top lvdc_assertions i_lvdc_assertions (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .cmp_raw, .cmp_ctrl, .internal_reset_req
);

// >>> verif/tb_top.sv
// Self-checking bench for the low-voltage detect control
`timescale 1ns/100ps
`include "lvdc_consts.svh"
module tb_top;
    import lvdc_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d, rd; logic [1:0] rs;} lvdc_row_t;
    localparam logic [7:0] A_MODE = `LVDC_OFS_MODE;
    localparam logic [7:0] A_LVL  = `LVDC_OFS_LEVEL;
    localparam logic [7:0] A_FLG  = `LVDC_OFS_FLAG;
    localparam logic [7:0] A_MSK  = `LVDC_OFS_MASK;
    localparam logic [7:0] A_MON  = `LVDC_OFS_MONITOR;
    logic        aclk, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    lvdc_cmp_t   cmp_raw = '0;
    lvdc_ana_t   cmp_ctrl;
    logic        internal_reset_req, lowvolt_irq;
    int          err_count = 0, cmp_count = 0, cyc_count = 0;
    lvdc_row_t   rows [7] = '{
        '{A_LVL, 32'h0000_0009, 32'h0000_0009, 2'h0}, '{A_MSK, 32'h0000_0000, 32'h0000_0000, 2'h0},
        '{A_MSK, 32'h0000_0001, 32'h0000_0001, 2'h0}, '{A_MODE, 32'h0000_0006, 32'h0000_0006, 2'h0},
        '{A_MODE, 32'h0000_0000, 32'h0000_0000, 2'h0}, '{8'h14, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2},
        '{A_FLG, 32'h0000_0001, 32'h0000_0000, 2'h0}};

    lvdc_top #(.ADDR_W(8)) i_lvdc_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cmp_raw, .cmp_ctrl, .internal_reset_req, .lowvolt_irq
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    // Address and data are offered together; each is released once taken
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        bit aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("bresp", s_axi_bresp, er);
    endtask : wchk

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check("rdata", s_axi_rdata, exp);
        check("rresp", s_axi_rresp, er);
    endtask : rchk

    // Hang guard, generous against a run of well under a thousand cycles
    always @(posedge aclk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 5000) begin
            err_count++;
            stop_test();
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            wchk(rows[i].a, rows[i].d, rows[i].rs);
            rchk(rows[i].a, rows[i].rd, rows[i].rs);
        end
        rchk(A_MON, 32'h0000_0000);
        // Second reset in mid-run restores the reset values
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(A_MODE, 32'h0000_0000);
        rchk(A_LVL, 32'h0000_0000);
        rchk(A_FLG, 32'h0000_0000);
        rchk(A_MSK, 32'h0000_0001);
        // A write with lane 0 disabled is answered but changes nothing
        s_axi_wstrb <= 4'h0;
        wchk(A_LVL, 32'h0000_0005);
        s_axi_wstrb <= 4'hF;
        rchk(A_LVL, 32'h0000_0000);
        // Interrupt mode, enabled while already below
        wchk(A_LVL, 32'h0000_0004);
        wchk(A_MSK, 32'h0000_0000);
        cmp_raw.supply_below <= 1'b1;
        wchk(A_MODE, 32'h0000_0001);
        repeat (8) @(posedge aclk);
        check("irq", lowvolt_irq, 1);
        check("rst_req", internal_reset_req, 0);
        rchk(A_FLG, 32'h0000_0001);
        wchk(A_MSK, 32'h0000_0001);
        repeat (3) @(posedge aclk);
        check("irq_masked", lowvolt_irq, 0);
        wchk(A_FLG, 32'h0000_0001);
        rchk(A_FLG, 32'h0000_0000);
        wchk(A_MODE, 32'h0000_0000);
        repeat (3) @(posedge aclk);
        rchk(A_FLG, 32'h0000_0001);
        wchk(A_MSK, 32'h0000_0000);
        wchk(A_MODE, 32'h0000_0001);
        for (int k = 0; k < 2; k++) begin
            wchk(A_FLG, 32'h0000_0001);
            cmp_raw.supply_below <= 1'b0;
            repeat (6) @(posedge aclk);
            check("irq", lowvolt_irq, 0);
            cmp_raw.supply_below <= 1'b1;
            repeat (6) @(posedge aclk);
            check("irq", lowvolt_irq, 1);
        end
        wchk(A_MODE, 32'h0000_0000);
        cmp_raw <= '0;
        wchk(A_FLG, 32'h0000_0001);
        // Reset mode chosen while above, then a chattering supply
        wchk(A_MODE, 32'h0000_0003);
        repeat (8) begin
            @(posedge aclk);
            check("rst_req", internal_reset_req, 0);
        end
        for (int k = 0; k < 2; k++) begin
            cmp_raw.supply_below <= 1'b1;
            repeat (6) @(posedge aclk);
            check("rst_req", internal_reset_req, 1);
            cmp_raw.supply_below <= 1'b0;
            repeat (6) @(posedge aclk);
            check("rst_req", internal_reset_req, 0);
        end
        rchk(A_FLG, 32'h0000_0000);
        wchk(A_MODE, 32'h0000_0000);
        // External source: supply level and level select are ignored
        wchk(A_LVL, 32'h0000_0009);
        cmp_raw.supply_below <= 1'b1;
        wchk(A_MODE, 32'h0000_0007);
        check("ctrl", cmp_ctrl, 32'h0000_0030);
        repeat (8) begin
            @(posedge aclk);
            check("rst_req", internal_reset_req, 0);
        end
        cmp_raw.ext_below <= 1'b1;
        repeat (6) @(posedge aclk);
        check("rst_req", internal_reset_req, 1);
        rchk(A_MON, 32'h0000_0007);
        wchk(A_MODE, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        check("rst_req", internal_reset_req, 0);
        // Stopped and back on the supply source, so the kept level select shows again
        check("ctrl", cmp_ctrl, 32'h0000_0009);
        stop_test();
    end
endmodule : tb_top
